// file: pkg/dpr_consts.vh
// constants for the dual-port ram port controller
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define DPR_CLK_MHZ 40
`define DPR_T_ACC_NS 55
`define DPR_T_SETUP_NS 20
`define DPR_T_PWE_NS 30
`define DPR_T_HZWE_NS 25
`define DPR_T_WH_NS 35
`define DPR_T_BDD_NS 45
`define DPR_T_BUSY_NS 30
`define DPR_CYC_UP(ns) ((((ns) * `DPR_CLK_MHZ) + 999) / 1000)
`define DPR_ACC_CYC `DPR_CYC_UP(`DPR_T_ACC_NS)
`define DPR_SETUP_CYC `DPR_CYC_UP(`DPR_T_SETUP_NS)
`define DPR_PWE_CYC `DPR_CYC_UP(`DPR_T_PWE_NS + `DPR_T_HZWE_NS)
`define DPR_WH_CYC `DPR_CYC_UP(`DPR_T_WH_NS)
`define DPR_BDD_CYC `DPR_CYC_UP(`DPR_T_BDD_NS)
`define DPR_BUSY_CYC `DPR_CYC_UP(`DPR_T_BUSY_NS)

// ---------------------------------------------------------------
// mailbox addresses
// ---------------------------------------------------------------
`define DPR_MBOX_LEFT 10'h3FF
`define DPR_MBOX_RIGHT 10'h3FE

`endif

// file: rtl/dpr_host.v
// one-port bus master driving a dual-port static ram
// How it works
// - leads under 5 ns leave winner open; host waits out busy either way
// - on slave parts write-select falls no earlier than busy high
// - write held by busy keeps write-select low a minimum after busy rises
// - write-select stays high through every read cycle
// - write pulse with output-enable low covers turn-off plus data set-up
// - write is the overlap of select and write-select low
`timescale 1ns/1ps
`include "dpr_consts.vh"

module dpr_host #(
  parameter AW = 10,
  parameter DW = 8,
  parameter LEFT_PORT = 1
) (
  input wire clk,
  input wire rst_n,
  input wire req_valid,
  input wire req_write,
  input wire req_mbox,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [DW-1:0] rsp_rdata,
  output reg irq_pending,
  output reg ram_ce_n,
  output reg ram_we_n,
  output reg ram_oe_n,
  output reg [AW-1:0] ram_addr,
  output reg [DW-1:0] ram_dq_o,
  output reg ram_dq_oe,
  input wire [DW-1:0] ram_dq_i,
  input wire ram_busy_n,
  input wire ram_int_n
);

  // ---------------------------------------------------------------
  // states and constants
  // ---------------------------------------------------------------
  localparam S_IDLE = 6'h01;
  localparam S_SETUP = 6'h02;
  localparam S_WRITE = 6'h04;
  localparam S_READ = 6'h08;
  localparam S_HOLD = 6'h10;
  localparam S_DONE = 6'h20;
  // timing counts cut to the counter width on purpose
  localparam integer ACC_N = `DPR_ACC_CYC;
  localparam integer SETUP_N = `DPR_SETUP_CYC;
  localparam integer PWE_N = `DPR_PWE_CYC;
  localparam integer WH_N = `DPR_WH_CYC;
  localparam integer BDD_N = `DPR_BDD_CYC;
  localparam integer BUSY_N = `DPR_BUSY_CYC;
  localparam [7:0] ACC_CYC = ACC_N[7:0];
  localparam [7:0] SETUP_CYC = SETUP_N[7:0];
  localparam [7:0] PWE_CYC = PWE_N[7:0];
  localparam [7:0] WH_CYC = WH_N[7:0];
  localparam [7:0] BDD_CYC = BDD_N[7:0];
  localparam [7:0] BUSY_CYC = BUSY_N[7:0];
  localparam [AW-1:0] MBOX_OWN = LEFT_PORT ? `DPR_MBOX_LEFT : `DPR_MBOX_RIGHT;
  localparam [AW-1:0] MBOX_PEER = LEFT_PORT ? `DPR_MBOX_RIGHT : `DPR_MBOX_LEFT;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  reg rst_a_ff;
  reg rst_b_ff;
  wire rst_sync_n = rst_b_ff;

  // two-stage reset release
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  reg busy_a_ff;
  reg busy_b_ff;
  reg int_a_ff;
  reg int_b_ff;
  reg [DW-1:0] dq_a_ff;
  reg [DW-1:0] dq_b_ff;

  // busy, interrupt and data pins pass two flops
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      busy_a_ff <= 1'b1;
      busy_b_ff <= 1'b1;
      int_a_ff <= 1'b1;
      int_b_ff <= 1'b1;
      dq_a_ff <= {DW{1'b0}};
      dq_b_ff <= {DW{1'b0}};
    end
    else
    begin
      busy_a_ff <= ram_busy_n;
      busy_b_ff <= busy_a_ff;
      int_a_ff <= ram_int_n;
      int_b_ff <= int_a_ff;
      dq_a_ff <= ram_dq_i;
      dq_b_ff <= dq_a_ff;
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  reg [5:0] state_ff;
  reg [7:0] cnt_ff;

  // one access at a time; select held only during an access
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      irq_pending <= 1'b0;
      ram_ce_n <= 1'b1;
      ram_we_n <= 1'b1;
      ram_oe_n <= 1'b1;
      ram_addr <= {AW{1'b0}};
      ram_dq_o <= {DW{1'b0}};
      ram_dq_oe <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      irq_pending <= ~int_b_ff;
      case (state_ff)
        S_IDLE:
        begin
          req_ready <= 1'b1;
          ram_ce_n <= 1'b1;
          ram_we_n <= 1'b1;
          ram_oe_n <= 1'b1;
          ram_dq_oe <= 1'b0;
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            // mailbox requests pick the fixed address
            if (req_mbox)
              ram_addr <= req_write ? MBOX_PEER : MBOX_OWN;
            else
              ram_addr <= req_addr;
            ram_dq_o <= req_wdata;
            ram_ce_n <= 1'b0; // select before write-select
            ram_we_n <= 1'b1;
            ram_oe_n <= req_write;
            // two extra cycles cover the pin synchroniser lag
            cnt_ff <= req_write ? (BUSY_CYC + 8'h02) : (ACC_CYC + 8'h02);
            state_ff <= req_write ? S_SETUP : S_READ;
          end
        end
        S_SETUP:
        begin
          // wait for arbitration to settle before the write pulse
          if (!busy_b_ff)
            cnt_ff <= BUSY_CYC;
          else if (cnt_ff > 8'h01)
            cnt_ff <= cnt_ff - 8'h01;
          else
          begin
            ram_we_n <= 1'b0;
            ram_dq_oe <= 1'b1;
            cnt_ff <= (PWE_CYC > SETUP_CYC) ? PWE_CYC : SETUP_CYC;
            state_ff <= S_WRITE;
          end
        end
        S_WRITE:
        begin
          // busy during the pulse defers the write
          if (!busy_b_ff)
          begin
            cnt_ff <= WH_CYC;
          end
          else if (cnt_ff > 8'h01)
            cnt_ff <= cnt_ff - 8'h01;
          else
          begin
            ram_we_n <= 1'b1; // write-select ends the write
            cnt_ff <= 8'h01;
            state_ff <= S_HOLD;
          end
        end
        S_READ:
        begin
          // busy restarts the wait with the busy-to-data time
          if (!busy_b_ff)
          begin
            cnt_ff <= BDD_CYC + 8'h02;
          end
          else if (cnt_ff > 8'h01)
            cnt_ff <= cnt_ff - 8'h01;
          else
          begin
            rsp_rdata <= dq_b_ff; // sampled after sync delay
            ram_oe_n <= 1'b1;
            state_ff <= S_DONE;
          end
        end
        S_HOLD:
        begin
          // data held one cycle past write-select rising
          ram_dq_oe <= 1'b0;
          ram_ce_n <= 1'b1;
          state_ff <= S_DONE;
        end
        S_DONE:
        begin
          // select toggles high between accesses
          ram_ce_n <= 1'b1;
          rsp_valid <= 1'b1;
          state_ff <= S_IDLE;
        end
        default:
        begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: sim/dpr_checker.sv
// pin protocol checker for the dual-port ram port controller
`timescale 1ns/1ps
module dpr_checker #(
  parameter DW = 8
) (
  input wire clk,
  input wire rst_n,
  input wire ram_ce_n,
  input wire ram_we_n,
  input wire ram_oe_n,
  input wire [DW-1:0] ram_dq_o,
  input wire ram_dq_oe,
  input wire ram_busy_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // ram control sequencing
  // ---------------------------------------------------------------
  a_read_we_high: assert property (!ram_oe_n |-> ram_we_n)
    else $error("write select low in read");
  a_pulse_three: assert property ($fell(ram_we_n) |-> !ram_we_n [*3])
    else $error("write pulse too short");
  a_write_overlap: assert property (!ram_we_n |-> !ram_ce_n && ram_dq_oe)
    else $error("write outside select");
  a_hold_data: assert property ($rose(ram_we_n) |-> ram_dq_oe && $stable(ram_dq_o))
    else $error("data moved at write end");
  a_busy_hold: assert property ($rose(ram_busy_n) && !ram_we_n |-> !ram_we_n [*2])
    else $error("write ended early after busy");
  a_wait_busy: assert property (!ram_busy_n && !ram_ce_n |=> !ram_ce_n)
    else $error("access dropped while busy");
  // main scenarios reached
  c_write: cover property ($rose(ram_we_n));
  c_read: cover property ($fell(ram_oe_n));
  c_busy_write: cover property (!ram_busy_n && !ram_we_n);
endmodule
bind dpr_host dpr_checker #(.DW(DW)) dpr_checker_inst (.clk(clk), .rst_n(rst_n),
  .ram_ce_n(ram_ce_n), .ram_we_n(ram_we_n), .ram_oe_n(ram_oe_n),
  .ram_dq_o(ram_dq_o), .ram_dq_oe(ram_dq_oe), .ram_busy_n(ram_busy_n));

// file: sim/dpr_ram_model.sv
// behavioural model of one port of the dual-port static ram
`timescale 1ns/1ps
`include "dpr_consts.vh"
module dpr_ram_model (
  input wire ram_ce_n,
  input wire ram_we_n,
  input wire ram_oe_n,
  input wire [9:0] ram_addr,
  input wire [7:0] dq,
  input wire busy_req,
  input wire post,
  output wire [7:0] ram_dq_i,
  output wire ram_busy_n,
  output wire ram_int_n,
  output wire peer_int_n
);
  reg [7:0] mem [0:1023];
  reg own_n = 1'b1;
  reg peer_n = 1'b1;
  wire rd = !ram_ce_n && !ram_oe_n && ram_we_n;
  // busy only reaches a selected port that contends
  assign #20 ram_busy_n = !(busy_req && !ram_ce_n);
  // stale or released lines show a moving pattern
  // data follows select, so a select toggle refreshes it
  assign #55 ram_dq_i = (rd && ram_busy_n) ? mem[ram_addr] : ~ram_addr[7:0];
  assign #45 ram_int_n = own_n;
  assign peer_int_n = peer_n;
  wire own_rd = rd && (ram_addr == `DPR_MBOX_LEFT);
  // write ends on write-select rising; a losing port is ignored
  always @(posedge ram_we_n)
    if (!ram_ce_n && ram_busy_n)
    begin
      mem[ram_addr] = dq;
      if (ram_addr == `DPR_MBOX_RIGHT)
        peer_n = 1'b0;
    end
  // peer posts to our mailbox; our read clears it
  always @(posedge post or posedge own_rd)
    own_n = own_rd ? 1'b1 : 1'b0;
endmodule

// file: sim/tb_top.sv
// self-checking bench for the dual-port ram port controller
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg req_valid = 1'b0;
  reg req_write = 1'b0;
  reg req_mbox = 1'b0;
  reg [9:0] req_addr = 10'h000;
  reg [7:0] req_wdata = 8'h00;
  reg busy_req = 1'b0;
  reg post = 1'b0;
  wire req_ready, rsp_valid, irq_pending, ram_ce_n, ram_we_n, ram_oe_n, ram_dq_oe;
  wire ram_busy_n, ram_int_n, peer_int_n;
  wire [7:0] rsp_rdata, ram_dq_o, ram_dq_i;
  wire [9:0] ram_addr;
  wire [7:0] dq = ram_dq_oe ? ram_dq_o : ram_dq_i;
  integer errors = 0;
  integer tests_run = 0;
  always #12.5 clk = ~clk;
  dpr_host dpr_host_inst (.clk, .rst_n, .req_valid, .req_write, .req_mbox, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .irq_pending, .ram_ce_n, .ram_we_n,
    .ram_oe_n, .ram_addr, .ram_dq_o, .ram_dq_oe, .ram_dq_i, .ram_busy_n, .ram_int_n);
  dpr_ram_model dpr_ram_model_inst (.ram_ce_n, .ram_we_n, .ram_oe_n, .ram_addr, .dq,
    .busy_req, .post, .ram_dq_i, .ram_busy_n, .ram_int_n, .peer_int_n);
  // compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // one request, held until taken, then wait for the response pulse
  task xfer(input w, input m, input [9:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      #2 {req_valid, req_write, req_mbox, req_addr, req_wdata} = {1'b1, w, m, a, d};
      do @(posedge clk); while (req_ready !== 1'b1 && ++n < 99);
      #2 req_valid = 1'b0;
      do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 300);
      chk({7'h00, rsp_valid}, 8'h01);
    end
  endtask
  // contending port holds busy for some cycles
  task contend;
    begin
      #2 busy_req = 1'b1;
      repeat (6) @(posedge clk);
      #2 busy_req = 1'b0;
    end
  endtask
  task t_rw;
    begin
      xfer(1, 0, 10'h000, 8'h5A);
      xfer(1, 0, 10'h3FD, 8'hA5);
      xfer(0, 0, 10'h000, 8'h00);
      chk(rsp_rdata, 8'h5A);
      xfer(0, 0, 10'h3FD, 8'h00);
      chk(rsp_rdata, 8'hA5);
    end
  endtask
  task t_busy;
    begin
      fork
        xfer(1, 0, 10'h155, 8'hC3);
        begin
          @(negedge ram_we_n);
          contend;
        end
      join
      xfer(0, 0, 10'h155, 8'h00);
      chk(rsp_rdata, 8'hC3);
      fork
        xfer(0, 0, 10'h155, 8'h00);
        begin
          @(negedge ram_ce_n);
          contend;
        end
      join
      chk(rsp_rdata, 8'hC3);
    end
  endtask
  task t_mbox;
    begin
      xfer(1, 1, 10'h000, 8'h77);
      chk({7'h00, peer_int_n}, 8'h00);
      #2 post = 1'b1;
      repeat (8) @(posedge clk);
      chk({7'h00, irq_pending}, 8'h01);
      xfer(0, 1, 10'h000, 8'h00);
      repeat (8) @(posedge clk);
      chk({7'h00, irq_pending}, 8'h00);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    t_rw;
    t_busy;
    t_mbox;
    tally_and_finish;
  end
  // watchdog, more than ten times the expected run
  initial
  begin
    #50000;
    errors = errors + 1;
    tally_and_finish;
  end
endmodule
